// ### src/msr_pkg.sv
package msr_pkg;

  // ==========================================================
  // clock and time base
  // ==========================================================
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;

  // ==========================================================
  // register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OVR_TIME_OFS = 8'h04;
  localparam logic [7:0] OVR_PULSE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] INT_STAT_OFS = 8'h10;
  localparam logic [7:0] INT_CLR_OFS = 8'h14;
  localparam logic [7:0] INT_EN_OFS = 8'h18;

  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int CTRL_OVR_EN_BIT = 0;
  localparam int STAT_ERR_POS = 4;
  localparam int STAT_FLAG_POS = 12;
  localparam int INT_ERR_BIT = 0;
  localparam int INT_OVR_REQ_BIT = 1;
  localparam int INT_START_BIT = 2;
  localparam int INT_W = 3;
  localparam int FAULT_W = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [15:0] OVR_TIME_RST = 16'h2710;
  localparam logic [15:0] OVR_PULSE_RST = 16'h0019;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    MSR_STOP, MSR_FIRST, MSR_NORMAL, MSR_BLOCKED, MSR_OVR_REQ, MSR_OVERRIDE
  } msr_state_t;

  // sensor side, all from pins
  typedef struct packed {
    logic override_in;
    logic espe_free;
    logic b2;
    logic b1;
    logic a2;
    logic a1;
  } msr_pins_t;

  typedef struct packed {
    logic release_out;
    logic err_flag;
    logic muting_err;
    logic ovr_required;
    logic muting_status;
  } msr_out_t;

endpackage

// ### src/msr_top.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module msr_top #(
  parameter int TICK_CYC = msr_pkg::TICK_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller state and field pins
  input wire logic run_in,
  input wire msr_pkg::msr_pins_t pins_in,
  // fault pulses from the sequencing logic, same clock
  input wire logic [msr_pkg::FAULT_W-1:0] fault_in,
  // outputs
  output msr_pkg::msr_out_t status_out,
  output logic irq
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  msr_pkg::msr_pins_t pins_s1_reg;
  msr_pkg::msr_pins_t pins_reg;
  logic run_s1_reg;
  logic run_reg;
  logic run_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_reg <= '0;
      pins_reg <= '0;
      run_s1_reg <= 1'b0;
      run_reg <= 1'b0;
      run_d_reg <= 1'b0;
    end else begin
      pins_s1_reg <= pins_in;
      pins_reg <= pins_s1_reg;
      run_s1_reg <= run_in;
      run_reg <= run_s1_reg;
      run_d_reg <= run_reg;
    end
  end

  logic all_low;
  logic part_met;
  logic cond_met;
  assign all_low = !(pins_reg.a1 | pins_reg.a2 | pins_reg.b1 | pins_reg.b2);
  assign part_met = !all_low;
  assign cond_met = (pins_reg.a1 & pins_reg.a2) | (pins_reg.b1 & pins_reg.b2);

  // ==========================================================
  // registers seen by software
  // ==========================================================
  logic [31:0] ctrl_reg;
  logic [15:0] ovr_time_reg;
  logic [15:0] ovr_pulse_reg;
  logic [msr_pkg::INT_W-1:0] int_stat_reg;
  logic [msr_pkg::INT_W-1:0] int_en_reg;
  logic wr_en;
  logic ovr_en;

  assign wr_en = psel & penable & pwrite;
  assign ovr_en = ctrl_reg[msr_pkg::CTRL_OVR_EN_BIT];
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= msr_pkg::CTRL_RST;
      ovr_time_reg <= msr_pkg::OVR_TIME_RST;
      ovr_pulse_reg <= msr_pkg::OVR_PULSE_RST;
      int_en_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        msr_pkg::CTRL_OFS: ctrl_reg <= pwdata;
        msr_pkg::OVR_TIME_OFS: ovr_time_reg <= pwdata[15:0];
        msr_pkg::OVR_PULSE_OFS: ovr_pulse_reg <= pwdata[15:0];
        msr_pkg::INT_EN_OFS: int_en_reg <= pwdata[msr_pkg::INT_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // override pulse qualification
  // ==========================================================
  // a short bounce on the key must not count as an override
  logic [15:0] ovr_hold_reg;
  logic ovr_valid;
  logic ovr_used_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_hold_reg <= '0;
    end else if (!pins_reg.override_in) begin
      ovr_hold_reg <= '0;
    end else if (ovr_hold_reg != 16'hFFFF) begin
      ovr_hold_reg <= ovr_hold_reg + 16'h0001;
    end
  end

  assign ovr_valid = ovr_en & pins_reg.override_in & (ovr_hold_reg >= ovr_pulse_reg);

  // one event per press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_used_reg <= 1'b0;
    end else begin
      ovr_used_reg <= ovr_valid;
    end
  end

  logic ovr_fire;
  assign ovr_fire = ovr_valid & !ovr_used_reg;

  // ==========================================================
  // millisecond timer for the override time
  // ==========================================================
  logic [31:0] pre_reg;
  logic tick;
  logic [15:0] ovr_ms_reg;
  logic ovr_expired;
  msr_pkg::msr_state_t state_reg;

  assign tick = (pre_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
    end else if (tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  // runs while override is wanted or in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_ms_reg <= '0;
    end else if (state_reg != msr_pkg::MSR_OVR_REQ && state_reg != msr_pkg::MSR_OVERRIDE) begin
      ovr_ms_reg <= '0;
    end else if (tick && !ovr_expired) begin
      ovr_ms_reg <= ovr_ms_reg + 16'h0001;
    end
  end

  assign ovr_expired = (ovr_ms_reg >= ovr_time_reg);

  // ==========================================================
  // muting error latch
  // ==========================================================
  logic [msr_pkg::FAULT_W-1:0] err_reg;
  logic clr_ok;
  logic muting_err;

  // either clearing path amounts to a valid muting cycle
  assign clr_ok = ovr_fire | (all_low & pins_reg.espe_free);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= '0;
    end else begin
      // a fault in the clearing cycle stays pending
      err_reg <= (clr_ok ? '0 : err_reg) | fault_in;
    end
  end

  assign muting_err = |err_reg;

  // ==========================================================
  // start-up and muting state machine
  // ==========================================================
  msr_pkg::msr_state_t state_next;
  logic armed_reg;
  logic mute_reg;
  logic start_evt;
  logic ovr_req_evt;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      msr_pkg::MSR_STOP: begin
        if (run_reg && !run_d_reg) begin
          state_next = msr_pkg::MSR_FIRST;
        end
      end
      // one cycle only; the start case is not looked at again until run_reg next rises
      msr_pkg::MSR_FIRST: begin
        if (!pins_reg.espe_free && all_low) begin
          state_next = msr_pkg::MSR_BLOCKED;
        end else if (!pins_reg.espe_free && ovr_en) begin
          state_next = msr_pkg::MSR_OVR_REQ;
        end else if (!pins_reg.espe_free) begin
          state_next = msr_pkg::MSR_BLOCKED;
        end else begin
          state_next = msr_pkg::MSR_NORMAL;
        end
      end
      msr_pkg::MSR_BLOCKED: begin
        if (pins_reg.espe_free) begin
          state_next = msr_pkg::MSR_NORMAL;
        end
      end
      msr_pkg::MSR_NORMAL: begin
        // sensors never cleared since start and OSSD already low
        if (!armed_reg && part_met && !pins_reg.espe_free && ovr_en) begin
          state_next = msr_pkg::MSR_OVR_REQ;
        end
      end
      msr_pkg::MSR_OVR_REQ: begin
        if (ovr_fire) begin
          state_next = msr_pkg::MSR_OVERRIDE;
        end else if (all_low) begin
          state_next = msr_pkg::MSR_NORMAL;
        end else if (ovr_expired) begin
          state_next = msr_pkg::MSR_BLOCKED;
        end
      end
      msr_pkg::MSR_OVERRIDE: begin
        if (all_low || ovr_expired) begin
          state_next = msr_pkg::MSR_NORMAL;
        end
      end
      default: state_next = msr_pkg::MSR_STOP;
    endcase
    if (!run_reg) begin
      state_next = msr_pkg::MSR_STOP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= msr_pkg::MSR_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // armed once every sensor has been seen low at the same time in any state after MSR_STOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (state_reg == msr_pkg::MSR_FIRST) begin
      armed_reg <= all_low;
    end else if (state_reg == msr_pkg::MSR_STOP) begin
      armed_reg <= 1'b0;
    end else if (all_low) begin
      armed_reg <= 1'b1;
    end
  end

  // muting starts only from a clean start, holds while sensors cover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_reg <= 1'b0;
    end else if (state_reg != msr_pkg::MSR_NORMAL || muting_err || all_low) begin
      mute_reg <= 1'b0;
    end else if (armed_reg && cond_met) begin
      mute_reg <= 1'b1;
    end
  end

  assign start_evt = (state_reg == msr_pkg::MSR_FIRST);
  assign ovr_req_evt = (state_next == msr_pkg::MSR_OVR_REQ) &&
    (state_reg != msr_pkg::MSR_OVR_REQ);

  // ==========================================================
  // outputs
  // ==========================================================
  logic in_ovr;
  logic release_next;
  msr_pkg::msr_out_t out_next;

  assign in_ovr = (state_reg == msr_pkg::MSR_OVERRIDE);
  // error always overrides every release reason
  assign release_next = !muting_err && (state_reg != msr_pkg::MSR_STOP) &&
    (state_reg != msr_pkg::MSR_FIRST) &&
    (mute_reg || in_ovr || pins_reg.espe_free);

  always_comb begin
    out_next.release_out = release_next;
    out_next.err_flag = muting_err;
    out_next.muting_err = muting_err;
    out_next.ovr_required = (state_reg == msr_pkg::MSR_OVR_REQ);
    out_next.muting_status = !muting_err && (mute_reg || in_ovr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out <= '0;
    end else begin
      status_out <= out_next;
    end
  end

  // ==========================================================
  // interrupt status
  // ==========================================================
  logic [msr_pkg::INT_W-1:0] int_set;
  logic [msr_pkg::INT_W-1:0] int_clr;

  assign int_set = {start_evt, ovr_req_evt, |fault_in};
  assign int_clr = (wr_en && paddr == msr_pkg::INT_CLR_OFS) ?
    pwdata[msr_pkg::INT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
    end else begin
      // a new event beats a clear in the same cycle
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
    end
  end

  assign irq = |(int_stat_reg & int_en_reg);

  // ==========================================================
  // read mux
  // ==========================================================
  logic [31:0] status_word;
  logic hit;

  assign status_word = {14'h0000, |out_next, 3'h0, err_reg, status_out, armed_reg,
    3'(state_reg)};

  always_comb begin
    prdata = '0;
    hit = 1'b1;
    case (paddr)
      msr_pkg::CTRL_OFS: prdata = ctrl_reg;
      msr_pkg::OVR_TIME_OFS: prdata = {16'h0000, ovr_time_reg};
      msr_pkg::OVR_PULSE_OFS: prdata = {16'h0000, ovr_pulse_reg};
      msr_pkg::STATUS_OFS: prdata = status_word;
      msr_pkg::INT_STAT_OFS: prdata = {29'h0000_0000, int_stat_reg};
      msr_pkg::INT_CLR_OFS: prdata = '0;
      msr_pkg::INT_EN_OFS: prdata = {29'h0000_0000, int_en_reg};
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & !hit;

endmodule

// ### testbench/msr_top_props.sv
`timescale 1ns/100ps
module msr_top_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // field side
  input wire logic run_in,
  input wire msr_pkg::msr_pins_t pins_in,
  input wire logic [msr_pkg::FAULT_W-1:0] fault_in,
  // outputs
  input wire msr_pkg::msr_out_t status_out
);
  logic any_s;
  assign any_s = pins_in.a1 | pins_in.a2 | pins_in.b1 | pins_in.b2;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // error handling
  // ==========================================================
  AST_FAULT_SETS: assert property (|fault_in |-> ##[1:2] status_out.muting_err)
    else $error("fault did not raise muting error");
  AST_ERR_GATES: assert property (status_out.muting_err |-> status_out.err_flag && !status_out.release_out)
    else $error("error without flag or with release");
  // six cycles covers the two-flop pin sync plus the output register
  AST_ERR_HOLDS: assert property ((status_out.muting_err && any_s && !pins_in.override_in)[*6] |=> status_out.muting_err)
    else $error("error cleared without a clearing cycle");
  AST_SET_WINS: assert property ($fell(status_out.muting_err) |-> $past(fault_in, 2) == '0)
    else $error("error cleared while a fault was pending");
  // ==========================================================
  // release and start-up
  // ==========================================================
  AST_FREE_RELEASE: assert property ((run_in && pins_in.espe_free && !status_out.muting_err && fault_in == '0)[*8] |-> status_out.release_out)
    else $error("release low with free curtain and no error");
  AST_BLOCKED: assert property ((!pins_in.espe_free && !any_s && !pins_in.override_in)[*6] |-> !status_out.release_out)
    else $error("release high with interrupted curtain and no muting");
  AST_STOPPED: assert property ((!run_in)[*6] |-> !status_out.release_out && !status_out.muting_status)
    else $error("outputs active while stopped");
  AST_FIRST_WAIT: assert property ((!run_in)[*6] ##1 run_in |-> (!status_out.release_out)[*3])
    else $error("release before start-up evaluation");
endmodule
bind msr_top msr_top_props u_msr_top_props (.pclk(pclk), .presetn(presetn), .run_in(run_in),
  .pins_in(pins_in), .fault_in(fault_in), .status_out(status_out));

// ### testbench/msr_field_model.sv
`timescale 1ns/100ps
module msr_field_model (
  // clock
  input wire logic pclk,
  // sensors, curtain and override switch
  output msr_pkg::msr_pins_t pins
);
  initial pins = '0;
  task automatic set_pins(input logic [5:0] v);
    @(posedge pclk);
    pins <= v;
  endtask
  // sensors drop ahead of the curtain
  task automatic leave_sensors_first();
    set_pins(6'h10);
    repeat (4) @(posedge pclk);
    pins.espe_free <= 1'b0;
  endtask
  // press while sensors are still up
  task automatic press_override(input int n);
    @(posedge pclk);
    pins.override_in <= 1'b1;
    repeat (n) @(posedge pclk);
    pins.override_in <= 1'b0;
  endtask
endmodule

// ### testbench/tb_msr_top.sv
`timescale 1ns/100ps
module tb_msr_top;
  logic pclk, presetn, psel, penable, pwrite, run_in, pready, pslverr, irq, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] fault_in;
  msr_pkg::msr_pins_t pins;
  msr_pkg::msr_out_t so;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  msr_top #(.TICK_CYC(10)) u_msr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_in(run_in), .pins_in(pins),
    .fault_in(fault_in), .status_out(so), .irq(irq));
  msr_field_model u_msr_field_model (.pclk(pclk), .pins(pins));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_state(input msr_pkg::msr_state_t s);
    apb(1'b0, msr_pkg::STATUS_OFS, 32'h0);
    check("state", {29'h0, rd[2:0]}, {29'h0, s});
  endtask
  task automatic start(input logic [5:0] p);
    run_in <= 1'b0;
    u_msr_field_model.set_pins(p);
    tick(8);
    run_in <= 1'b1;
    tick(10);
  endtask
  // ==========================================================
  // sequence
  // ==========================================================
  initial begin
    {psel, penable, pwrite, run_in, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    fault_in = '0;
    tick(8);
    presetn <= 1'b1;
    apb(1'b0, msr_pkg::CTRL_OFS, 32'h0);
    check("ctrl", rd, msr_pkg::CTRL_RST);
    apb(1'b0, msr_pkg::OVR_TIME_OFS, 32'h0);
    check("ovr_time", rd, {16'h0, msr_pkg::OVR_TIME_RST});
    apb(1'b0, msr_pkg::OVR_PULSE_OFS, 32'h0);
    check("ovr_pulse", rd, {16'h0, msr_pkg::OVR_PULSE_RST});
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped", {slv, rd[30:0]}, 32'h8000_0000);
    start(6'h10);
    check("release", so.release_out, 1'b1);
    chk_state(msr_pkg::MSR_NORMAL);
    u_msr_field_model.set_pins(6'h13);
    tick(6);
    check("muting", so.muting_status, 1'b1);
    for (int i = 0; i < 5; i++) begin
      // alternate pairs so both sensor pairs see use
      u_msr_field_model.set_pins(i[0] ? 6'h1C : 6'h13);
      @(posedge pclk);
      fault_in <= 5'h01 << i;
      @(posedge pclk);
      fault_in <= '0;
      tick(8);
      check("err", {so.muting_err, so.err_flag, so.release_out, so.muting_status}, 4'b1100);
      u_msr_field_model.set_pins(6'h10);
      tick(8);
      check("err_clr", {so.muting_err, so.release_out}, 2'b01);
    end
    fault_in <= 5'h01;
    tick(6);
    check("pending", so.muting_err, 1'b1);
    fault_in <= '0;
    tick(6);
    check("cleared", so.muting_err, 1'b0);
    check("irq_masked", irq, 1'b0);
    apb(1'b1, msr_pkg::INT_EN_OFS, 32'h1);
    // the enable lands at the access edge; look one edge later
    tick(1);
    check("irq", irq, 1'b1);
    apb(1'b1, msr_pkg::INT_CLR_OFS, 32'h7);
    apb(1'b0, msr_pkg::INT_STAT_OFS, 32'h0);
    check("int_clr", rd, 32'h0);
    check("irq_clr", irq, 1'b0);
    start(6'h00);
    chk_state(msr_pkg::MSR_BLOCKED);
    u_msr_field_model.set_pins(6'h10);
    tick(6);
    check("unblock", so.release_out, 1'b1);
    start(6'h03);
    check("ovr_req", so.ovr_required, 1'b1);
    chk_state(msr_pkg::MSR_OVR_REQ);
    u_msr_field_model.set_pins(6'h00);
    tick(8);
    chk_state(msr_pkg::MSR_NORMAL);
    start(6'h03);
    u_msr_field_model.press_override(30);
    tick(4);
    check("ovr_rel", {so.release_out, so.muting_status}, 2'b11);
    apb(1'b1, msr_pkg::OVR_TIME_OFS, 32'h2);
    start(6'h03);
    tick(30);
    chk_state(msr_pkg::MSR_BLOCKED);
    start(6'h11);
    u_msr_field_model.leave_sensors_first();
    tick(6);
    check("drop", {so.release_out, so.muting_err}, 2'b00);
    // reset in mid-run with run still high: registers back, start case judged again
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    apb(1'b0, msr_pkg::OVR_TIME_OFS, 32'h0);
    check("ovr_time_rst", rd, {16'h0, msr_pkg::OVR_TIME_RST});
    tick(8);
    chk_state(msr_pkg::MSR_BLOCKED);
    give_verdict();
  end
endmodule
